/* File: inc/sar_adc_consts.svh */
// constants for the successive-approximation converter control
`ifndef SAR_ADC_CONSTS_SVH
`define SAR_ADC_CONSTS_SVH
`define CLK_PERIOD_NS 40
`define RESULT_WIDTH 16
`define FIFO_DEPTH 16
`define ACQ_TIME_NS 2000
`define ACQ_CYCLES ((`ACQ_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STEP_DIV 4
`define RESET_CODE 16'h0000
`endif

/* File: inc/sar_adc_pkg.sv */
// types for the successive-approximation converter control
package sar_adc_pkg;
  typedef enum logic [1:0] {
    ST_ACQUIRE = 2'b00,
    ST_CONVERT = 2'b01,
    ST_LATCH = 2'b10,
    ST_DONE = 2'b11
  } conv_state_t;
endpackage : sar_adc_pkg

/* File: verilog/pin_sync.sv */
// two-flop synchroniser for asynchronous pins
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinOut
);
  logic [WIDTH-1:0] stage1;

  initial begin
    if (WIDTH < 1) $error("pin_sync: WIDTH must be positive");
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stage1 <= INIT;
      pinOut <= INIT;
    end else begin
      stage1 <= pinIn;
      pinOut <= stage1;
    end
  end
endmodule : pin_sync
`default_nettype wire

/* File: verilog/result_fifo.sv */
// result word FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module result_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;
  logic doWrite;
  logic doRead;

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("result_fifo: DEPTH must be a power of two");
  end

  assign inReady = (count != DEPTH[AW:0]);
  assign outValid = (count != '0);
  assign outData = mem[rdPtr];
  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;

  always_ff @(posedge clk_sys) begin
    if (doWrite) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doWrite) wrPtr <= wrPtr + 1'b1;
      if (doRead) rdPtr <= rdPtr + 1'b1;
      if (doWrite && !doRead) count <= count + 1'b1;
      else if (doRead && !doWrite) count <= count - 1'b1;
    end
  end
endmodule : result_fifo
`default_nettype wire

/* File: verilog/sar_adc_control.sv */
// conversion control and parallel readout of a successive-approximation converter
`timescale 1ns/1ns
`default_nettype none
`include "sar_adc_consts.svh"
// Contract
// R1 - select low: convert falling starts conversion
// R2 - select low: convert rising enables outputs
// R3 - convert low: select falling starts conversion
// R4 - convert high: select falling enables outputs
// R5 - select and convert combined as OR
// R6 - outputs float if select high/convert low
// R7 - byte low: msb on top line
// R8 - byte high: upper and lower bytes swapped
// R9 - busy low throughout conversion
// R10 - result valid when busy rises
// R11 - host holds an input high at busy rise
// R12 - host returns convert high within 3us
// R13 - approximation register cleared at start
// R14 - start requests ignored while converting
// R15 - bits decided msb down to lsb
// R16 - finished word copied into output latches
// R17 - host allows 2us acquisition between conversions
// R18 - auto-zero closed in acquire, open converting
// R19 - result is two's complement
// R20 - host holds convert low at least 40ns
// R21 - internal clock steps bits, busy after latch
// R22 - latches hold result until next completion
module sar_adc_control #(
  parameter int WIDTH = `RESULT_WIDTH,
  parameter int DEPTH = `FIFO_DEPTH,
  parameter int STEP_DIV = `STEP_DIV
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic chipSelect_b,
  input wire logic readConvert,
  input wire logic byteSelect,
  input wire logic compareHigh,
  output logic sampleHold,
  output logic autoZero,
  output logic [WIDTH-1:0] dacCode,
  output logic busy_b,
  output logic [WIDTH-1:0] resultBusOut,
  output logic [WIDTH-1:0] resultBusOe,
  output logic [WIDTH-1:0] streamData,
  output logic streamValid,
  input wire logic streamReady
);
  localparam int BW = $clog2(WIDTH);
  localparam int HALF = WIDTH / 2;

  logic csSync;
  logic rcSync;
  logic byteSync;
  logic cmpSync;
  logic gateNow;
  logic gatePrev;
  logic rcPrev;
  logic startReq;
  logic readReq;
  sar_adc_pkg::conv_state_t state;
  logic [WIDTH-1:0] approximation_register;
  logic [WIDTH-1:0] trialBit;
  logic [BW-1:0] bitIndex;
  logic [7:0] stepCount;
  logic stepTick;
  logic [WIDTH-1:0] outLatch;
  logic driveEn;
  logic fifoInReady;
  logic fifoValid;
  logic [WIDTH-1:0] fifoData;
  logic pushPending;

  initial begin
    if (WIDTH < 4 || (WIDTH % 2) != 0) $error("sar_adc_control: WIDTH must be even and >= 4");
    // each bit needs a dac update and two synchroniser stages before its decision
    if (STEP_DIV < 4 || STEP_DIV > 255) $error("sar_adc_control: STEP_DIV out of range");
  end

  function automatic logic [WIDTH-1:0] swap_bytes(input logic [WIDTH-1:0] w, input logic sw);
    swap_bytes = sw ? {w[HALF-1:0], w[WIDTH-1:HALF]} : w;
  endfunction : swap_bytes

  pin_sync #(.WIDTH(4), .INIT(4'hD)) u_pins (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .pinIn({chipSelect_b, readConvert, byteSelect, compareHigh}),
    .pinOut({csSync, rcSync, byteSync, cmpSync})
  );

  // the combined gate is low only when both inputs are low
  assign gateNow = csSync | rcSync; // R5

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      gatePrev <= 1'b1;
      rcPrev <= 1'b1;
    end else begin
      gatePrev <= gateNow;
      rcPrev <= rcSync;
    end
  end

  // a falling combined gate covers both start modes
  assign startReq = gatePrev && !gateNow; // R1 R3
  // read strobe: gate clear of convert with select low
  assign readReq = !csSync && rcSync && (!rcPrev || gatePrev); // R2 R4

  // bit-step divider standing in for the internal trimmed clock
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stepCount <= 8'h00;
    end else if (state != sar_adc_pkg::ST_CONVERT || stepTick) begin
      stepCount <= 8'h00;
    end else begin
      stepCount <= stepCount + 8'h01;
    end
  end
  assign stepTick = (stepCount == 8'(STEP_DIV - 1)); // R21

  assign trialBit = {{(WIDTH-1){1'b0}}, 1'b1} << bitIndex;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state <= sar_adc_pkg::ST_ACQUIRE;
      approximation_register <= '0;
      bitIndex <= '0;
    end else begin
      case (state)
        sar_adc_pkg::ST_ACQUIRE: begin
          if (startReq) begin
            approximation_register <= '0; // R13
            bitIndex <= BW'(WIDTH - 1); // R15
            state <= sar_adc_pkg::ST_CONVERT;
          end
        end
        // starts arriving here are not looked at
        sar_adc_pkg::ST_CONVERT: begin // R14
          if (stepTick) begin
            // keep the trial bit when the input is at or above the dac level
            if (cmpSync) approximation_register <= approximation_register | trialBit; // R15
            if (bitIndex == '0) state <= sar_adc_pkg::ST_LATCH;
            else bitIndex <= bitIndex - 1'b1; // R15
          end
        end
        sar_adc_pkg::ST_LATCH: state <= sar_adc_pkg::ST_DONE;
        sar_adc_pkg::ST_DONE: state <= sar_adc_pkg::ST_ACQUIRE;
        default: state <= sar_adc_pkg::ST_ACQUIRE;
      endcase
    end
  end

  // dac trial code: decided bits plus the bit under test
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dacCode <= '0;
    end else if (state == sar_adc_pkg::ST_CONVERT) begin
      dacCode <= approximation_register | trialBit;
    end else begin
      dacCode <= approximation_register;
    end
  end

  // comparator is referenced as two's complement: msb compare inverted
  // by the analog side, so the register holds the code directly
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      outLatch <= `RESET_CODE;
    end else if (state == sar_adc_pkg::ST_LATCH) begin // R22
      outLatch <= approximation_register; // R16 R19
    end
  end
  // outLatch changes nowhere else, so repeated reads match

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      busy_b <= 1'b1;
      sampleHold <= 1'b0;
      autoZero <= 1'b1;
    end else begin
      // busy falls on start, rises one cycle after the latch load
      busy_b <= !(startReq && state == sar_adc_pkg::ST_ACQUIRE) &&
                !(state == sar_adc_pkg::ST_CONVERT) &&
                !(state == sar_adc_pkg::ST_LATCH); // R9 R10 R21
      sampleHold <= (startReq && state == sar_adc_pkg::ST_ACQUIRE) ||
                    state == sar_adc_pkg::ST_CONVERT; // R1
      autoZero <= !((startReq && state == sar_adc_pkg::ST_ACQUIRE) ||
                    state == sar_adc_pkg::ST_CONVERT); // R18
    end
  end

  // output enable follows the gate; read strobe arms it
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      driveEn <= 1'b0;
    end else if (csSync || !rcSync) begin
      driveEn <= 1'b0; // R6
    end else if (readReq) begin
      driveEn <= 1'b1; // R2 R4
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      resultBusOut <= '0;
      resultBusOe <= '0;
    end else begin
      resultBusOut <= swap_bytes(outLatch, byteSync); // R7 R8
      resultBusOe <= (driveEn && !csSync && rcSync) ? '1 : '0; // R6
    end
  end

  // each finished word is also offered on the stream; a full fifo
  // leaves one push waiting, carrying the newest word, and never stalls conversion
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pushPending <= 1'b0;
    end else if (state == sar_adc_pkg::ST_DONE) begin
      pushPending <= 1'b1;
    end else if (fifoInReady) begin
      pushPending <= 1'b0;
    end
  end

  result_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .inData(outLatch),
    .inValid(pushPending),
    .inReady(fifoInReady),
    .outData(fifoData),
    .outValid(fifoValid),
    .outReady(streamReady && !streamValid)
  );

  // registered stream stage so outputs come from flops
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      streamValid <= 1'b0;
      streamData <= '0;
    end else if (streamValid) begin
      if (streamReady) streamValid <= 1'b0;
    end else if (fifoValid && streamReady) begin
      streamValid <= 1'b1;
      streamData <= fifoData;
    end
  end

  // length of the current busy span, checked when busy rises
  logic [15:0] busyLowCount;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      busyLowCount <= 16'h0000;
    end else if (busy_b) begin
      busyLowCount <= 16'h0000;
    end else begin
      busyLowCount <= busyLowCount + 16'h0001;
    end
  end

  sequence startSeen_s;
    startReq && state == sar_adc_pkg::ST_ACQUIRE;
  endsequence

  sequence gateFall_s;
    gatePrev && !gateNow;
  endsequence

  sequence readGate_s;
    !csSync && rcSync;
  endsequence

  sequence bitStep_s;
    state == sar_adc_pkg::ST_CONVERT && stepTick && bitIndex != '0;
  endsequence

  // start and bit sequence
  busyFalls_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R9
    startSeen_s |=> !busy_b) else $error("busy did not fall on start");
  startTaken_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R1 R3 R5
    state == sar_adc_pkg::ST_ACQUIRE ##0 gateFall_s |=> state == sar_adc_pkg::ST_CONVERT)
    else $error("falling gate did not start a conversion");
  clearAtStart_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R13
    startSeen_s |=> approximation_register == '0) else $error("register not cleared");
  msbFirst_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R15
    startSeen_s |=> bitIndex == BW'(WIDTH - 1)) else $error("conversion not from msb");
  bitOrder_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R15
    bitStep_s |=> bitIndex == $past(bitIndex) - 1'b1) else $error("bit order broken");
  trialCode_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R15
    state == sar_adc_pkg::ST_CONVERT |=> dacCode == $past(approximation_register | trialBit))
    else $error("trial code wrong");
  noRestart_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R14
    state == sar_adc_pkg::ST_CONVERT && !stepTick |=> state == sar_adc_pkg::ST_CONVERT)
    else $error("conversion restarted");
  holdInConvert_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R1
    state == sar_adc_pkg::ST_CONVERT |=> sampleHold) else $error("sampler left hold");
  autoZeroOpen_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R18
    state == sar_adc_pkg::ST_CONVERT |=> !autoZero) else $error("auto-zero closed");
  zeroInAcquire_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R18
    state == sar_adc_pkg::ST_ACQUIRE && !startReq |=> autoZero && !sampleHold)
    else $error("sampler not tracking in acquire");
  releaseHold_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R18
    state == sar_adc_pkg::ST_LATCH |=> autoZero && !sampleHold)
    else $error("sampler not released after conversion");

  // busy and result latch
  busyLow_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R9
    state == sar_adc_pkg::ST_CONVERT || state == sar_adc_pkg::ST_LATCH |=> !busy_b)
    else $error("busy high during conversion");
  busyRise_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R10 R21
    state == sar_adc_pkg::ST_DONE |=> busy_b) else $error("busy did not rise after latch");
  busySpan_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R9 R21
    $rose(busy_b) |-> busyLowCount == 16'(WIDTH * STEP_DIV + 2))
    else $error("busy span has the wrong length");
  latchLoad_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R16
    state == sar_adc_pkg::ST_LATCH |=> outLatch == $past(approximation_register))
    else $error("latch not loaded");
  dataAtBusy_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R10
    $rose(busy_b) |-> outLatch == $past(approximation_register, 2))
    else $error("result not valid at busy rise");
  latchHold_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R22
    state != sar_adc_pkg::ST_LATCH |=> $stable(outLatch))
    else $error("latch changed outside a completion");

  // readout
  floatBus_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R6
    (csSync || !rcSync) |=> resultBusOe == '0) else $error("bus driven while gated");
  readEnable_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R2 R4
    readGate_s [*2] |=> resultBusOe == '1) else $error("bus not driven on read");
  byteStraight_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R7
    !byteSync |=> resultBusOut == $past(outLatch))
    else $error("straight byte order wrong");
  byteSwap_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R8
    byteSync |=> resultBusOut[HALF-1:0] == $past(outLatch[WIDTH-1:HALF]))
    else $error("byte swap wrong");
  byteSwapHigh_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R8
    byteSync |=> resultBusOut[WIDTH-1:HALF] == $past(outLatch[HALF-1:0]))
    else $error("byte swap wrong in upper byte");
  streamHold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    streamValid && !streamReady |=> streamValid && $stable(streamData))
    else $error("stream word dropped before acceptance");
endmodule : sar_adc_control
`default_nettype wire

/* File: verif/comparator_model.sv */
// comparator model that judges each trial code against a held input level
`timescale 1ns/1ns
`default_nettype none
module comparator_model (
  input wire logic [15:0] dacCode,
  input wire logic [15:0] level,
  output logic compareHigh
);
  // keeping a trial bit while the trial is not above the level makes the result equal the level
  assign compareHigh = (dacCode <= level);
endmodule : comparator_model
`default_nettype wire

/* File: verif/sar_adc_conversion_and_readout_tb.sv */
// self-checking bench for conversion start, parallel readout and result stream
`timescale 1ns/1ns
`default_nettype none
module sar_adc_conversion_and_readout_tb;
  localparam int STEP = 4;
  localparam int BUSY_LOW = 16 * STEP + 2;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic chipSelect_b = 1'b1;
  logic readConvert = 1'b1;
  logic byteSelect = 1'b0;
  logic streamReady = 1'b0;
  logic [15:0] level = 16'h0000;
  logic compareHigh, sampleHold, autoZero, busy_b, streamValid;
  logic [15:0] dacCode, resultBusOut, resultBusOe, streamData;
  int bad_count = 0;
  int cmp_count = 0;
  int seed = 69;
  logic [15:0] expQ[$];
  logic [15:0] vals[4] = '{16'h8000, 16'h7FFF, 16'hFFFF, 16'h0000};

  sar_adc_control #(.STEP_DIV(STEP)) sar_adc_control_i (
    .clk_sys(clk_sys), .rst_b(rst_b), .chipSelect_b(chipSelect_b),
    .readConvert(readConvert), .byteSelect(byteSelect), .compareHigh(compareHigh),
    .sampleHold(sampleHold), .autoZero(autoZero), .dacCode(dacCode), .busy_b(busy_b),
    .resultBusOut(resultBusOut), .resultBusOe(resultBusOe), .streamData(streamData),
    .streamValid(streamValid), .streamReady(streamReady)
  );
  comparator_model comparator_model_i (
    .dacCode(dacCode), .level(level), .compareHigh(compareHigh)
  );

  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : tick

  task automatic end_sim;
    if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  task automatic chk_word(input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk_word

  task automatic chk_flag(input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk_flag

  task automatic convert(input logic [15:0] t, input logic viaCs);
    int n;
    logic seen;
    level = t;
    seen = 1'b0;
    if (viaCs) begin
      // select rises as convert falls, so only the select edge can start
      chipSelect_b = 1'b1;
      readConvert = 1'b0;
      tick(1);
    end
    chipSelect_b = 1'b0;
    readConvert = 1'b0;
    n = 0;
    while (busy_b !== 1'b0 && n < 10) begin
      tick(1);
      n++;
    end
    chk_flag(1'b1, sampleHold);
    chk_flag(1'b0, autoZero);
    n = 0;
    while (busy_b === 1'b0 && n < 200) begin
      if (dacCode === 16'h8000) seen = 1'b1;
      if (n == 1) chk_word(16'h0000, resultBusOe);
      if (n == 2 && viaCs) chipSelect_b = 1'b1;
      if (n == 2 && !viaCs) readConvert = 1'b1;
      // a second start request in mid-conversion must leave the busy span untouched
      if (n == 12 && viaCs) chipSelect_b = 1'b0;
      if (n == 12 && !viaCs) readConvert = 1'b0;
      if (n == 14) chipSelect_b = viaCs;
      if (n == 14) readConvert = 1'b1;
      if (n == 20 && viaCs) chk_word(16'h0000, resultBusOe);
      tick(1);
      n++;
    end
    chk_word(16'(BUSY_LOW), n[15:0]);
    chk_flag(1'b1, seen);
    chk_flag(1'b0, sampleHold);
    chk_flag(1'b1, autoZero);
    // sixteen fifo words plus one waiting push that each newer word replaces
    if (expQ.size() < 17) expQ.push_back(t);
    else expQ[16] = t;
  endtask : convert

  task automatic read(input logic [15:0] t, input logic viaCs);
    int n;
    if (viaCs) chipSelect_b = 1'b0;
    n = 0;
    while (resultBusOe !== 16'hFFFF && n < 10) begin
      tick(1);
      n++;
    end
    tick(1);
    chk_word(16'hFFFF, resultBusOe);
    chk_word(t, resultBusOut);
    byteSelect = 1'b1;
    tick(4);
    chk_word({t[7:0], t[15:8]}, resultBusOut);
    byteSelect = 1'b0;
    tick(4);
    chk_word(t, resultBusOut);
    if (viaCs) begin
      chipSelect_b = 1'b1;
      tick(4);
      chk_word(16'h0000, resultBusOe);
    end
    tick(55);
  endtask : read

  initial begin
    logic [15:0] t;
    int got;
    repeat (4) @(posedge clk_sys);
    #2;
    chk_flag(1'b1, busy_b);
    chk_word(16'h0000, resultBusOe);
    chk_flag(1'b0, streamValid);
    tick(4);
    rst_b = 1'b1;
    tick(3);
    // stream sink stalls through every conversion so the fifo fills and the last word waits as a pending push
    for (int i = 0; i < 17; i++) begin
      t = (i < 4) ? vals[i] : 16'($random(seed));
      convert(t, i[0]);
      read(t, i[0]);
    end
    got = 0;
    for (int c = 0; c < 300; c++) begin
      streamReady = (c % 11) < 7;
      #1;
      if (streamValid === 1'b1 && streamReady) begin
        if (expQ.size() > 0) chk_word(expQ.pop_front(), streamData);
        got++;
      end
      tick(1);
    end
    chk_word(16'd17, got[15:0]);
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    end_sim();
  end
endmodule : sar_adc_conversion_and_readout_tb
`default_nettype wire
